/* File: logic/vcsw_defines.svh */
`ifndef VCSW_DEFINES_SVH
`define VCSW_DEFINES_SVH

// register byte offsets on the bus
`define VCSW_OFS_CTRL 8'h00
`define VCSW_OFS_TXDATA 8'h04
`define VCSW_OFS_RXDATA 8'h08
`define VCSW_OFS_STATUS 8'h0C
`define VCSW_OFS_OFFSET 8'h10

// field positions
`define VCSW_CTRL_LINEAR 0
`define VCSW_ST_RXNEW 2
`define VCSW_ST_TXTAKEN 3

// word lengths in bit clocks
`define VCSW_WORD_COMP 5'h08
`define VCSW_WORD_LIN 5'h10

// attenuation step per code count
`define VCSW_ATTEN_STEP_DB 5'h03

// core cycles of a steady high receive bit clock that mean fixed rate
`define VCSW_FIXED_DETECT 7'h40

// offset averager: shift and saturation limits
`define VCSW_AZ_SHIFT 6
`define VCSW_AZ_LIMIT_P 18'h0_FFFF
`define VCSW_AZ_LIMIT_N 18'h3_0001

// mu-law bias and magnitude clip on the 14-bit scale
`define VCSW_MU_BIAS 14'h0021
`define VCSW_MU_CLIP 14'h1FDE

`endif

/* File: logic/vcsw_pkg.sv */
package vcsw_pkg;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SEND = 3'b010,
      TX_HOLD = 3'b100
   } vcsw_tx_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_TAKE = 3'b010,
      RX_HOLD = 3'b100
   } vcsw_rx_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } vcsw_sync_t;

   typedef struct packed {
      vcsw_tx_t txSt;
      vcsw_rx_t rxSt;
      logic linear;
      logic varRate;
      logic [6:0] fixCnt;
      logic [12:0] txSample;
      logic [12:0] heldSample;
      logic [17:0] azAcc;
      logic [15:0] txWord;
      logic [4:0] txIdx;
      logic dataOut;
      logic dataOutOe;
      logic slotOe;
      logic [15:0] rxShift;
      logic [4:0] rxCnt;
      logic rxDone;
      logic [12:0] rxLin;
      logic [2:0] rxAtten;
      logic [4:0] rxDb;
      logic rxNew;
      logic txTaken;
      logic dataPh;
      logic phWrite;
      logic [7:0] phAddr;
      logic [31:0] hrdata;
      logic readyOut;
      logic respOut;
      logic strobeLow;
   } vcsw_state_t;

endpackage : vcsw_pkg

/* File: logic/vcsw_ifs.sv */
`timescale 1ns/1ps
// synchronised pin: level plus one-cycle edge pulses
interface vcsw_sync_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : vcsw_sync_if

// mu-law encoder and decoder pair
interface vcsw_law_if;
   logic [12:0] encIn;
   logic [7:0] encOut;
   logic [7:0] decIn;
   logic [12:0] decOut;
   modport codec (input encIn, input decIn, output encOut, output decOut);
   modport user (output encIn, output decIn, input encOut, input decOut);
endinterface : vcsw_law_if

/* File: logic/vcsw_pin_sync.sv */
`timescale 1ns/1ps
module vcsw_pin_sync (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pin,
   vcsw_sync_if.src sync
);
   import vcsw_pkg::*;

   vcsw_sync_t st_r;
   vcsw_sync_t st_nxt;

   // s1 only feeds s2; edges are found between s2 and s3
   always_comb begin
      st_nxt.s1 = pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync.level = st_r.s2;
   assign sync.rise = st_r.s2 & ~st_r.s3;
   assign sync.fall = ~st_r.s2 & st_r.s3;

endmodule : vcsw_pin_sync

/* File: logic/vcsw_mulaw.sv */
`timescale 1ns/1ps
`include "vcsw_defines.svh"
module vcsw_mulaw (
   vcsw_law_if.codec law
);
   import vcsw_pkg::*;

   logic [13:0] mag;
   logic [2:0] seg;
   logic [3:0] mant;
   logic [2:0] dSeg;
   logic [3:0] dMant;
   logic [13:0] dMag;
   logic [13:0] lin14;

   // encoder: 13-bit sample scaled to 14 bits, clipped, biased, segmented
   always_comb begin
      mag = law.encIn[12] ? 14'(-{law.encIn, 1'b0}) : {law.encIn, 1'b0};
      if (mag > `VCSW_MU_CLIP) begin
         mag = `VCSW_MU_CLIP;
      end
      mag = 14'(mag + `VCSW_MU_BIAS);
      seg = 3'd0;
      for (int i = 0; i < 8; i++) begin
         if (mag[i + 5]) begin
            seg = 3'(i);
         end
      end
      mant = 4'(mag >> (4'(seg) + 4'd1));
      law.encOut = {~law.encIn[12], ~seg, ~mant}; // sign first, positive reads 1
   end

   // decoder: inverse of the encoder, result halved back to 13 bits
   always_comb begin
      dSeg = ~law.decIn[6:4];
      dMant = ~law.decIn[3:0];
      dMag = 14'((({9'h000, dMant, 1'b0} + `VCSW_MU_BIAS) << dSeg) - `VCSW_MU_BIAS);
      lin14 = law.decIn[7] ? dMag : 14'(-dMag);
      law.decOut = lin14[13:1];
   end

endmodule : vcsw_mulaw

/* File: logic/vcsw_word_port.sv */
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "vcsw_defines.svh"
module vcsw_word_port (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic masterClock,
   input wire logic txFrameSync,
   input wire logic rxFrameSync,
   input wire logic rxBitClock,
   input wire logic txSlotOrBitClockIn,
   output logic txSlotStrobeNOut,
   output logic txSlotStrobeNOe,
   input wire logic micSilenceN,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOutOe
);
   import vcsw_pkg::*;

   vcsw_state_t st_r;
   vcsw_state_t st_nxt;
   logic [4:0] wordLen;
   logic txBitRise;
   logic rxBitFall;
   logic muted;
   logic txLoad;
   logic varComp;
   logic addrPh;
   logic [12:0] offset;
   logic [12:0] corrected;
   logic [31:0] rdVal;

   vcsw_sync_if mclkS ();
   vcsw_sync_if txClkS ();
   vcsw_sync_if rxClkS ();
   vcsw_sync_if txFsS ();
   vcsw_sync_if rxFsS ();
   vcsw_sync_if muteS ();
   vcsw_sync_if dinS ();
   vcsw_law_if law ();

   // every serial-port pin from outside is brought in through two flops first; the bus inputs are used directly
   vcsw_pin_sync uMclk (.core_clk(core_clk), .nrst(nrst), .pin(masterClock), .sync(mclkS));
   vcsw_pin_sync uTxClk (.core_clk(core_clk), .nrst(nrst), .pin(txSlotOrBitClockIn),
      .sync(txClkS));
   vcsw_pin_sync uRxClk (.core_clk(core_clk), .nrst(nrst), .pin(rxBitClock), .sync(rxClkS));
   vcsw_pin_sync uTxFs (.core_clk(core_clk), .nrst(nrst), .pin(txFrameSync), .sync(txFsS));
   vcsw_pin_sync uRxFs (.core_clk(core_clk), .nrst(nrst), .pin(rxFrameSync), .sync(rxFsS));
   vcsw_pin_sync uMute (.core_clk(core_clk), .nrst(nrst), .pin(micSilenceN), .sync(muteS));
   vcsw_pin_sync uDin (.core_clk(core_clk), .nrst(nrst), .pin(dataIn), .sync(dinS));
   vcsw_mulaw uLaw (.law(law));

   // encoder sees the held sample, decoder the low byte of the receive shifter
   assign law.encIn = st_r.heldSample;
   assign law.decIn = st_r.rxShift[7:0];

   // shared decode terms; edges of the chosen bit clock drive each channel
   always_comb begin
      wordLen = st_r.linear ? `VCSW_WORD_LIN : `VCSW_WORD_COMP;
      txBitRise = st_r.varRate ? txClkS.rise : mclkS.rise;
      rxBitFall = st_r.varRate ? rxClkS.fall : mclkS.fall;
      muted = ~muteS.level;
      txLoad = (st_r.txSt == TX_IDLE) && txFsS.rise;
      varComp = st_r.varRate && !st_r.linear;
      addrPh = hsel && htrans[1] && hready && (hsize == 3'b010);
      offset = 13'($signed(st_r.azAcc) >>> `VCSW_AZ_SHIFT);
      corrected = 13'(st_r.txSample - offset);
   end

   // register read mux, sampled in the address phase
   always_comb begin
      rdVal = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000) begin
         case (haddr[7:0])
            `VCSW_OFS_CTRL: rdVal = {31'h0000_0000, st_r.linear};
            `VCSW_OFS_TXDATA: rdVal = {19'h0_0000, st_r.txSample};
            `VCSW_OFS_RXDATA: rdVal = {3'h0, st_r.rxDb, 5'h00, st_r.rxAtten, 3'h0, st_r.rxLin};
            `VCSW_OFS_STATUS: rdVal = {28'h000_0000, st_r.txTaken, st_r.rxNew, muted,
               st_r.varRate};
            `VCSW_OFS_OFFSET: rdVal = {19'h0_0000, offset};
            default: rdVal = 32'h0000_0000;
         endcase
      end
   end

   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.readyOut = 1'b1;
      st_nxt.respOut = 1'b0;
      st_nxt.strobeLow = 1'b0;
      st_nxt.rxDone = 1'b0;

      // bus slave: zero wait states, writes land in the data phase
      st_nxt.dataPh = addrPh && (haddr[31:8] == 24'h00_0000);
      st_nxt.phWrite = hwrite;
      st_nxt.phAddr = haddr[7:0];
      if (addrPh && !hwrite) begin
         st_nxt.hrdata = rdVal;
      end
      if (st_r.dataPh && st_r.phWrite) begin
         case (st_r.phAddr)
            `VCSW_OFS_CTRL: st_nxt.linear = hwdata[`VCSW_CTRL_LINEAR];
            `VCSW_OFS_TXDATA: st_nxt.txSample = hwdata[12:0];
            `VCSW_OFS_STATUS: begin
               if (hwdata[`VCSW_ST_RXNEW]) st_nxt.rxNew = 1'b0;
               if (hwdata[`VCSW_ST_TXTAKEN]) st_nxt.txTaken = 1'b0;
            end
            default: st_nxt.linear = st_r.linear;
         endcase
      end

      // rate detect: a falling receive clock means variable rate; the low synchroniser
      // level out of reset is no fall, so a tied-high clock stays fixed from the start
      if (rxClkS.fall) begin
         st_nxt.varRate = 1'b1;
      end
      if (!rxClkS.level) begin
         st_nxt.fixCnt = 7'h00;
      end else if (st_r.fixCnt != `VCSW_FIXED_DETECT) begin
         st_nxt.fixCnt = 7'(st_r.fixCnt + 7'h01);
      end else begin
         st_nxt.varRate = 1'b0;
      end

      // transmit channel; its rate select comes from the receive bit clock
      case (st_r.txSt)
         TX_IDLE: begin
            if (txLoad) begin
               // word is built from last frame's sample, this frame's is held
               if (muted) begin
                  st_nxt.txWord = 16'h0000;
               end else if (st_r.linear) begin
                  st_nxt.txWord = {st_r.heldSample, 3'b000};
               end else begin
                  st_nxt.txWord = {law.encOut, 8'h00};
               end
               st_nxt.heldSample = corrected;
               st_nxt.txTaken = 1'b1;
               st_nxt.txIdx = 5'h00;
               st_nxt.txSt = TX_SEND;
               // long-term sign average, saturating so it cannot wrap
               if (!corrected[12] && st_r.azAcc != `VCSW_AZ_LIMIT_P) begin
                  st_nxt.azAcc = 18'(st_r.azAcc + 18'h0_0001);
               end else if (corrected[12] && st_r.azAcc != `VCSW_AZ_LIMIT_N) begin
                  st_nxt.azAcc = 18'(st_r.azAcc - 18'h0_0001);
               end
            end
         end
         TX_SEND: begin
            if (st_r.varRate && !txFsS.level) begin
               st_nxt.dataOutOe = 1'b0;
               st_nxt.slotOe = 1'b0;
               st_nxt.txSt = TX_IDLE;
            end else if (txBitRise) begin
               if (st_r.txIdx == wordLen) begin
                  if (st_r.varRate) begin
                     st_nxt.dataOut = st_r.txWord[15];
                     st_nxt.txIdx = 5'h01;
                  end else begin
                     st_nxt.dataOutOe = 1'b0;
                     st_nxt.slotOe = 1'b0;
                     st_nxt.txSt = TX_HOLD;
                  end
               end else begin
                  st_nxt.dataOut = st_r.txWord[4'(4'hF - st_r.txIdx[3:0])];
                  st_nxt.dataOutOe = 1'b1;
                  st_nxt.slotOe = !st_r.varRate;
                  st_nxt.txIdx = 5'(st_r.txIdx + 5'h01);
               end
            end
         end
         TX_HOLD: begin
            if (!txFsS.level) st_nxt.txSt = TX_IDLE;
         end
         default: begin
            st_nxt.txSt = TX_IDLE;
            st_nxt.dataOutOe = 1'b0;
            st_nxt.slotOe = 1'b0;
         end
      endcase

      // receive channel; own frame sync, own bit clock at variable rate and master clock at fixed rate
      case (st_r.rxSt)
         RX_IDLE: begin
            if (rxFsS.rise) begin
               st_nxt.rxCnt = 5'h00;
               st_nxt.rxSt = RX_TAKE;
            end
         end
         RX_TAKE: begin
            if (varComp && !rxFsS.level) begin
               // last eight bits of the slot are the word
               st_nxt.rxDone = (st_r.rxCnt == wordLen);
               st_nxt.rxSt = RX_IDLE;
            end else if (st_r.varRate && !rxFsS.level) begin
               st_nxt.rxSt = RX_IDLE; // short linear word dropped
            end else if (rxBitFall) begin
               st_nxt.rxShift = {st_r.rxShift[14:0], dinS.level};
               if (st_r.rxCnt != wordLen) begin
                  st_nxt.rxCnt = 5'(st_r.rxCnt + 5'h01);
               end
               if (!varComp && st_r.rxCnt == 5'(wordLen - 5'h01)) begin
                  st_nxt.rxDone = 1'b1; // first eight or sixteen bits
                  st_nxt.rxSt = RX_HOLD;
               end
            end
         end
         RX_HOLD: begin
            if (!rxFsS.level) st_nxt.rxSt = RX_IDLE;
         end
         default: st_nxt.rxSt = RX_IDLE;
      endcase

      // unpack a finished word; attenuation is rewritten by every word
      if (st_r.rxDone) begin
         st_nxt.rxNew = 1'b1;
         if (st_r.linear) begin
            st_nxt.rxLin = st_r.rxShift[15:3];
            st_nxt.rxAtten = st_r.rxShift[2:0];
            st_nxt.rxDb = 5'({2'b00, st_r.rxShift[2:0]} * `VCSW_ATTEN_STEP_DB);
         end else begin
            st_nxt.rxLin = law.decOut;
            st_nxt.rxAtten = 3'b000;
            st_nxt.rxDb = 5'h00;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.txSt <= TX_IDLE;
         st_r.rxSt <= RX_IDLE;
         st_r.readyOut <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output comes straight from the state register
   assign hrdata = st_r.hrdata;
   assign hreadyout = st_r.readyOut;
   assign hresp = st_r.respOut;
   assign dataOut = st_r.dataOut;
   assign dataOutOe = st_r.dataOutOe;
   assign txSlotStrobeNOut = st_r.strobeLow;
   assign txSlotStrobeNOe = st_r.slotOe;

   // checks on the transmit path
   mute_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (txLoad && muted) |=> (st_r.txWord == 16'h0000))
      else $error("muted frame did not load zero code");
   lin_pad_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (txLoad && st_r.linear) |=> (st_r.txWord[2:0] == 3'b000))
      else $error("linear transmit trailing bits not zero");
   comp_word_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (txLoad && !st_r.linear && !muted) |=> (st_r.txWord[15:8] == $past(law.encOut)))
      else $error("companded word not the encoded held sample");
   held_next_a: assert property (@(posedge core_clk) disable iff (!nrst)
      txLoad |=> (st_r.heldSample == $past(corrected) && st_r.txSt == TX_SEND))
      else $error("sample not held for next frame");
   first_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_r.txSt == TX_SEND && txBitRise && st_r.txIdx == 5'h00
         && (!st_r.varRate || txFsS.level))
      |=> (st_r.dataOut == st_r.txWord[15] && st_r.dataOutOe))
      else $error("sign bit not first on the output");
   repeat_word_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_r.txSt == TX_SEND && st_r.varRate && txFsS.level && txBitRise
         && st_r.txIdx == wordLen)
      |=> (st_r.txIdx == 5'h01 && st_r.dataOut == st_r.txWord[15]))
      else $error("variable rate word not repeated");
   az_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (txLoad && !corrected[12] && st_r.azAcc != `VCSW_AZ_LIMIT_P)
      |=> (st_r.azAcc == 18'($past(st_r.azAcc) + 18'h0_0001)))
      else $error("offset average did not follow sign");

   // checks on the receive path and rate select
   rx_lin_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_r.rxDone && st_r.linear) |=> (st_r.rxLin == $past(st_r.rxShift[15:3]) && st_r.rxNew))
      else $error("linear sample not taken from first 13 bits");
   rx_atten_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_r.rxDone && st_r.linear)
      |=> (st_r.rxAtten == $past(st_r.rxShift[2:0])
         && st_r.rxDb == 5'({2'b00, $past(st_r.rxShift[2:0])} * 5'h03)))
      else $error("attenuation code or level wrong");
   rx_comp_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (st_r.rxDone && !st_r.linear) |=> (st_r.rxLin == $past(law.decOut) && st_r.rxAtten == 3'b000))
      else $error("companded word not decoded");
   rate_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
      rxClkS.fall |=> (st_r.varRate && st_r.fixCnt == 7'h00))
      else $error("toggling receive clock did not select variable rate");

endmodule : vcsw_word_port

/* File: testbench/vcsw_dsp_port.sv */
`timescale 1ns/1ps
// behavioural dsp serial port: master clock, frame syncs, bit clocks, receive data
module vcsw_dsp_port (
   input wire logic core_clk,
   output logic masterClock,
   output logic txFrameSync,
   output logic rxFrameSync,
   output logic rxBitClock,
   output logic txSlotOrBitClockIn,
   output logic dataIn,
   input wire logic dataOut,
   input wire logic dataOutOe,
   input wire logic txSlotStrobeNOut,
   input wire logic txSlotStrobeNOe
);
   logic varMode = 1'b0;
   logic gate = 1'b0;
   logic [31:0] txCap;
   int stbCnt;

   // master clock runs free, phase unrelated to the core clock
   initial begin
      masterClock = 1'b0;
      txFrameSync = 1'b0;
      rxFrameSync = 1'b0;
      dataIn = 1'b0;
      #41;
      forever #100 masterClock = ~masterClock;
   end

   // at variable rate the bit clocks follow the master clock inside a frame only, else stand still low
   assign rxBitClock = varMode ? (masterClock & gate) : 1'b1; // held high means fixed
   // open-drain strobe with pull-up while in fixed rate
   assign txSlotOrBitClockIn = varMode ? (masterClock & gate)
                                       : (txSlotStrobeNOe ? txSlotStrobeNOut : 1'b1);

   // an undriven output reads as unknown so it can never match
   task automatic capture;
      txCap = {txCap[30:0], dataOutOe ? dataOut : 1'bx};
      if (txSlotStrobeNOe === 1'b1) stbCnt++;
   endtask : capture

   // one frame: both syncs together, n bit clocks, receive word sent msb first
   task automatic frame(input int n, input logic [15:0] rxw);
      txCap = 32'h0000_0000;
      stbCnt = 0;
      @(negedge masterClock);
      @(posedge core_clk);
      txFrameSync <= 1'b1;
      rxFrameSync <= 1'b1;
      gate <= 1'b1;
      dataIn <= rxw[15]; // sample bits lead, control bits trail
      for (int i = 0; i < n; i++) begin
         @(posedge masterClock);
         if (i > 0) capture();
         if (i > 0) dataIn <= rxw[15 - i]; // change on rise, taken on fall
      end
      @(negedge masterClock);
      gate <= 1'b0;
      @(posedge masterClock);
      capture();
      txFrameSync <= 1'b0;
      rxFrameSync <= 1'b0;
      dataIn <= ~dataIn; // released line must not show the last bit
      repeat (3) @(posedge masterClock);
   endtask : frame
endmodule : vcsw_dsp_port

/* File: testbench/vcsw_word_port_tb.sv */
`timescale 1ns/1ps
module vcsw_word_port_tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic micSilenceN = 1'b1;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic masterClock, txFrameSync, rxFrameSync, rxBitClock, txPin, dataIn;
   logic txSlotStrobeNOut, txSlotStrobeNOe, dataOut, dataOutOe;
   logic [31:0] rdv;
   int failures = 0;
   int checked = 0;

   // core clock, 25 ns period
   always #12.5 core_clk = ~core_clk;

   vcsw_word_port dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .masterClock(masterClock),
      .txFrameSync(txFrameSync), .rxFrameSync(rxFrameSync), .rxBitClock(rxBitClock),
      .txSlotOrBitClockIn(txPin), .txSlotStrobeNOut(txSlotStrobeNOut),
      .txSlotStrobeNOe(txSlotStrobeNOe), .micSilenceN(micSilenceN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOutOe(dataOutOe));

   vcsw_dsp_port dsp (.core_clk(core_clk), .masterClock(masterClock),
      .txFrameSync(txFrameSync), .rxFrameSync(rxFrameSync), .rxBitClock(rxBitClock),
      .txSlotOrBitClockIn(txPin), .dataIn(dataIn), .dataOut(dataOut), .dataOutOe(dataOutOe),
      .txSlotStrobeNOut(txSlotStrobeNOut), .txSlotStrobeNOe(txSlotStrobeNOe));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // single word transfer; holds each phase until hready is sampled high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus

   // reference mu-law encoder on the doubled 14-bit scale, positive samples only
   function automatic logic [7:0] mu(input logic [12:0] s);
      logic [13:0] m;
      logic [2:0] seg;
      m = {s, 1'b0};
      if (m > 14'h1FDE) m = 14'h1FDE;
      m = m + 14'h0021;
      seg = 3'b000;
      for (int k = 1; k < 8; k++) if (m >= (14'h0020 << k)) seg = 3'(k);
      return ~{1'b0, seg, 4'(m >> (seg + 1))};
   endfunction : mu

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   task automatic t_regs;
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
      chk({30'h0000_0000, hresp, txSlotStrobeNOut}, 32'h0000_0000);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[0]}, 32'h0000_0000);
      $display("t_regs done");
   endtask : t_regs

   // companded transmit: a sample goes out one frame after it is taken
   task automatic t_comp_tx;
      bus(1'b1, 8'h00, 32'h0000_0000);
      bus(1'b1, 8'h04, 32'h0000_0100);
      dsp.frame(8, 16'h0000);
      dsp.frame(8, 16'h0000);
      chk(dsp.txCap, {24'h00_0000, mu(13'h0100)});
      chk(32'(dsp.stbCnt), 32'h0000_0008);
      bus(1'b1, 8'h04, 32'h0000_0040);
      dsp.frame(8, 16'h0000);
      chk(dsp.txCap, {24'h00_0000, mu(13'h0100)});
      dsp.frame(8, 16'h0000);
      chk(dsp.txCap, {24'h00_0000, mu(13'h0040)});
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[3]}, 32'h0000_0001);
      $display("t_comp_tx done");
   endtask : t_comp_tx

   task automatic t_mute;
      micSilenceN <= 1'b0;
      dsp.frame(8, 16'h0000);
      dsp.frame(8, 16'h0000);
      chk(dsp.txCap, 32'h0000_0000);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[1]}, 32'h0000_0001);
      micSilenceN <= 1'b1;
      $display("t_mute done");
   endtask : t_mute

   task automatic t_lin_tx;
      bus(1'b1, 8'h00, 32'h0000_0001);
      bus(1'b1, 8'h04, 32'h0000_0A5C);
      dsp.frame(16, 16'h0000);
      dsp.frame(16, 16'h0000);
      chk(dsp.txCap, 32'h0000_52E0);
      $display("t_lin_tx done");
   endtask : t_lin_tx

   // every attenuation code, each word carrying its own, ending on zero
   task automatic t_lin_rx;
      logic [12:0] smp;
      for (int c = 7; c >= 0; c--) begin
         smp = 13'h1000 + 13'(c);
         dsp.frame(16, {smp, 3'(c)}); // code sent in every word
         bus(1'b0, 8'h08, 32'h0000_0000);
         chk(rdv, {3'b000, 5'(c * 3), 5'b00000, 3'(c), 3'b000, smp});
      end
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[2]}, 32'h0000_0001);
      bus(1'b1, 8'h0C, 32'h0000_0004);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[2]}, 32'h0000_0000);
      $display("t_lin_rx done");
   endtask : t_lin_rx

   task automatic t_comp_rx;
      bus(1'b1, 8'h00, 32'h0000_0000);
      dsp.frame(8, 16'hBE00);
      bus(1'b0, 8'h08, 32'h0000_0000);
      chk(rdv, 32'h0000_0107);
      $display("t_comp_rx done");
   endtask : t_comp_rx

   // variable rate: word repeats while sync stays high, receive keeps the last eight
   task automatic t_var;
      dsp.varMode <= 1'b1;
      // the rate select only shows after the receive clock has crossed the synchroniser
      repeat (4) @(posedge core_clk);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk({31'h0000_0000, rdv[0]}, 32'h0000_0001);
      bus(1'b1, 8'h04, 32'h0000_0040);
      dsp.frame(16, 16'h0000);
      dsp.frame(16, 16'h55BE);
      chk(dsp.txCap, {16'h0000, mu(13'h0040), mu(13'h0040)});
      bus(1'b0, 8'h08, 32'h0000_0000);
      chk(rdv, 32'h0000_0107);
      // variable rate linear: one full word each way, held sample 0x40 goes out padded
      bus(1'b1, 8'h00, 32'h0000_0001);
      dsp.frame(16, 16'hA00D);
      chk(dsp.txCap, 32'h0000_0200);
      bus(1'b0, 8'h08, 32'h0000_0000);
      chk(rdv, 32'h0F05_1401);
      bus(1'b0, 8'h10, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
      $display("t_var done");
   endtask : t_var

   // watchdog sized well above the frames the tests need
   initial begin
      #2_000_000;
      failures++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end

   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_comp_tx();
      t_mute();
      t_lin_tx();
      t_lin_rx();
      t_comp_rx();
      t_var();
      test_done();
   end
endmodule : vcsw_word_port_tb
